// ==== sce_cfg_check.sv ====
// module: setup consistency checker, registered error code
module sce_cfg_check (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst,
    // setup under test
    input  wire sce_pkg::sce_cfg_t cfg,
    // lowest active setup error code, zero when clean
    output logic [7:0]           code_q
);
    import sce_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decoded setup properties
    wire pv_diff  = cfg.process_value_source == PV_DIFF12 ||
                    cfg.process_value_source == PV_DIFF21;
    wire sp_input = cfg.setpoint_source == SP_IN1 || cfg.setpoint_source == SP_IN2;
    // any zero band or integral time drops output one out of pid mode
    wire pid_off  = cfg.proportional_band_one == 8'h00 ||
                    cfg.proportional_band_two == 8'h00 ||
                    cfg.integral_time_one == 8'h00 || cfg.integral_time_two == 8'h00;
    wire a1_diff  = cfg.alarm_one_function >= ALM_DIF_L &&
                    cfg.alarm_one_function <= ALM_DIF_H;
    wire a2_diff  = cfg.alarm_two_function >= ALM_DIF_L &&
                    cfg.alarm_two_function <= ALM_DIF_H;
    wire unit_ne  = cfg.input_one_unit != cfg.input_two_unit ||
                    cfg.input_one_decimal_point != cfg.input_two_decimal_point;

    // one term per illegal combination
    wire chk1 = cfg.process_value_source == PV_IN1 && cfg.setpoint_source == SP_IN1;
    wire chk2 = cfg.process_value_source == PV_IN2 && cfg.setpoint_source == SP_IN2;
    wire chk3 = pv_diff && sp_input;
    wire chk4 = cfg.output_two_function == O2_COOL &&
                (cfg.direct_cooling_action || pid_off);
    wire chk5 = unit_ne && (pv_diff || sp_input || a1_diff || a2_diff);
    wire chk6 = cfg.output_two_function == O2_ALARM &&
                cfg.alarm_two_function == ALM_NONE;
    wire chk7 = cfg.alarm_one_function == ALM_DWELL &&
                cfg.alarm_two_function == ALM_DWELL;

    // lowest number wins so the front panel shows a stable single code
    wire [7:0] code_d = chk1 ? ERR_PV1  : chk2 ? ERR_PV2  : chk3 ? ERR_DIFF :
                        chk4 ? ERR_COOL : chk5 ? ERR_UNIT : chk6 ? ERR_ALM2 :
                        chk7 ? ERR_DWELL : ERR_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // re-evaluated every cycle, held while the condition stands
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            code_q <= ERR_NONE;
        end else begin
            code_q <= code_d;
        end
    end

    a_same_src_one: assert property (@(posedge ref_clk) disable iff (rst)
        chk1 |=> code_q == ERR_PV1) else $error("input one double use not coded 1");
    a_cool_conflict: assert property (@(posedge ref_clk) disable iff (rst)
        chk4 && !chk1 && !chk2 && !chk3 |=> code_q == ERR_COOL)
        else $error("cooling conflict not coded 4");
    a_dwell_both: assert property (@(posedge ref_clk) disable iff (rst)
        chk7 && !(chk1 || chk2 || chk3 || chk4 || chk5 || chk6) |=> code_q == ERR_DWELL)
        else $error("double dwell timer not coded 7");
    a_code_held: assert property (@(posedge ref_clk) disable iff (rst)
        $stable(cfg) && code_q != ERR_NONE |=> code_q == $past(code_q))
        else $error("setup code changed without a setup change");
endmodule

// ==== sce_master.sv ====
// partner model: remote communication master sending one request at a time
module sce_master (
    // clock
    input  wire logic        ref_clk,
    // request toward the block
    output sce_pkg::sce_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    import sce_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    initial req = '0;
    // request held one cycle; lines scrambled after release so stale values never match
    task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, f, a, d};
        @(posedge ref_clk);
        req <= '{1'b0, ~f, ~a, ~d};
    endtask
endmodule

// ==== sce_pkg.sv ====
// package: constants and carrier types of the setup check and error reporter
package sce_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // register port offsets
    localparam logic [7:0] OFF_SRC  = 8'h00;
    localparam logic [7:0] OFF_OUT  = 8'h04;
    localparam logic [7:0] OFF_PID  = 8'h08;
    localparam logic [7:0] OFF_INP  = 8'h0C;
    localparam logic [7:0] OFF_ALM  = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_ERR  = 8'h1C;
    // reset values
    localparam logic [3:0]  SRC_RST  = 4'h0;
    localparam logic [2:0]  OUT_RST  = 3'h0;
    localparam logic [31:0] PID_RST  = 32'h1414_1414;
    localparam logic [7:0]  INP_RST  = 8'h00;
    localparam logic [7:0]  ALM_RST  = 8'h00;
    localparam logic [2:0]  MASK_RST = 3'h0;
    // status bit positions
    localparam int ST_SETUP = 0;
    localparam int ST_COMM  = 1;
    localparam int ST_TUNE  = 2;
    localparam int ST_W     = 3;
    ////////////////////////////////////////////////////////////////////////////
    // setting encodings
    localparam logic [1:0] PV_IN1    = 2'h0;
    localparam logic [1:0] PV_IN2    = 2'h1;
    localparam logic [1:0] PV_DIFF12 = 2'h2;
    localparam logic [1:0] PV_DIFF21 = 2'h3;
    localparam logic [1:0] SP_LOCAL  = 2'h0;
    localparam logic [1:0] SP_IN1    = 2'h1;
    localparam logic [1:0] SP_IN2    = 2'h2;
    localparam logic [1:0] O2_NONE   = 2'h0;
    localparam logic [1:0] O2_COOL   = 2'h1;
    localparam logic [1:0] O2_ALARM  = 2'h2;
    localparam logic [3:0] ALM_NONE  = 4'h0;
    localparam logic [3:0] ALM_DWELL = 4'h1;
    localparam logic [3:0] ALM_DIF_L = 4'h2;
    localparam logic [3:0] ALM_DIF_H = 4'h5;
    // error codes
    localparam logic [7:0] ERR_NONE  = 8'h00;
    localparam logic [7:0] ERR_PV1   = 8'h01;
    localparam logic [7:0] ERR_PV2   = 8'h02;
    localparam logic [7:0] ERR_DIFF  = 8'h03;
    localparam logic [7:0] ERR_COOL  = 8'h04;
    localparam logic [7:0] ERR_UNIT  = 8'h05;
    localparam logic [7:0] ERR_ALM2  = 8'h06;
    localparam logic [7:0] ERR_DWELL = 8'h07;
    localparam logic [7:0] CE_FUNC   = 8'h0A;
    localparam logic [7:0] CE_ADDR   = 8'h0B;
    localparam logic [7:0] CE_PARAM  = 8'h0C;
    localparam logic [7:0] CE_RO     = 8'h0E;
    localparam logic [7:0] CE_RANGE  = 8'h0F;
    localparam logic [7:0] TE_FAIL   = 8'h14;
    localparam logic [7:0] TE_EVENT  = 8'h1A;
    // remote function codes
    localparam logic [7:0] FC_READ   = 8'h03;
    localparam logic [7:0] FC_WRITE  = 8'h06;
    ////////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic [1:0] process_value_source;
        logic [1:0] setpoint_source;
        logic       direct_cooling_action;
        logic [1:0] output_two_function;
        logic [7:0] proportional_band_one;
        logic [7:0] proportional_band_two;
        logic [7:0] integral_time_one;
        logic [7:0] integral_time_two;
        logic [1:0] input_one_unit;
        logic [1:0] input_two_unit;
        logic [1:0] input_one_decimal_point;
        logic [1:0] input_two_decimal_point;
        logic [3:0] alarm_one_function;
        logic [3:0] alarm_two_function;
    } sce_cfg_t;
    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] data;
    } sce_req_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } sce_resp_t;
    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [15:0] data;
    } sce_par_t;
endpackage

// ==== sce_top.sv ====
// module: setup check, remote request check and tuning fault reporter

////////////////////////////////////////////////////////////////////////////////
module sce_top #(
    parameter int               REG_COUNT       = 64,
    parameter logic [63:0]      PARAM_PRESENT   = 64'h0000_FFFF_FFFF_FFFF,
    parameter logic [63:0]      PARAM_READ_ONLY = 64'h0000_0000_0000_00FF,
    parameter logic [15:0]      VALUE_MAX       = 16'h270F
) (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // remote request and its answer
    input  wire sce_pkg::sce_req_t req,
    output sce_pkg::sce_resp_t     resp,
    // parameter store write
    output sce_pkg::sce_par_t      par_wr,
    // tuning and event input
    input  wire logic              tune_active,
    input  wire logic              tune_pid_bad,
    input  wire logic              tune_abort,
    input  wire logic              event_pin,
    // alarm two path
    input  wire logic              alarm_two_raw,
    output logic                   alarm_two_out,
    // error report
    output logic [7:0]             err_code,
    output logic                   irq
);
    import sce_pkg::*;

    localparam int IW = $clog2(REG_COUNT);

    ////////////////////////////////////////////////////////////////////////////
    // software setup registers and report state
    logic [3:0]      src_q;
    logic [2:0]      out_q;
    logic [31:0]     pid_q;
    logic [7:0]      inp_q;
    logic [7:0]      alm_q;
    logic [ST_W-1:0] mask_q;
    logic [ST_W-1:0] stat_q;
    logic [7:0]      evt_code_q;
    logic [7:0]      cfg_prev_q;
    logic            evt_s1_q;
    logic            evt_s2_q;
    logic            evt_s3_q;
    logic [7:0]      cfg_code;
    sce_cfg_t        cfg;

    // write and status read decode
    wire wr_src  = reg_wr && reg_addr == OFF_SRC;
    wire wr_out  = reg_wr && reg_addr == OFF_OUT;
    wire wr_pid  = reg_wr && reg_addr == OFF_PID;
    wire wr_inp  = reg_wr && reg_addr == OFF_INP;
    wire wr_alm  = reg_wr && reg_addr == OFF_ALM;
    wire wr_mask = reg_wr && reg_addr == OFF_MASK;
    wire err_clr = reg_wr && reg_addr == OFF_ERR;
    wire rd_stat = reg_rd && reg_addr == OFF_STAT;

    // setup fields as the checker sees them
    assign cfg.process_value_source    = src_q[1:0];
    assign cfg.setpoint_source         = src_q[3:2];
    assign cfg.direct_cooling_action   = out_q[0];
    assign cfg.output_two_function     = out_q[2:1];
    assign cfg.proportional_band_one   = pid_q[7:0];
    assign cfg.proportional_band_two   = pid_q[15:8];
    assign cfg.integral_time_one       = pid_q[23:16];
    assign cfg.integral_time_two       = pid_q[31:24];
    assign cfg.input_one_unit          = inp_q[1:0];
    assign cfg.input_two_unit          = inp_q[3:2];
    assign cfg.input_one_decimal_point = inp_q[5:4];
    assign cfg.input_two_decimal_point = inp_q[7:6];
    assign cfg.alarm_one_function      = alm_q[3:0];
    assign cfg.alarm_two_function      = alm_q[7:4];

    // setup registers hold until software rewrites them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_q  <= SRC_RST;
            out_q  <= OUT_RST;
            pid_q  <= PID_RST;
            inp_q  <= INP_RST;
            alm_q  <= ALM_RST;
            mask_q <= MASK_RST;
        end else begin
            if (wr_src)  src_q  <= reg_wdata[3:0];
            if (wr_out)  out_q  <= reg_wdata[2:0];
            if (wr_pid)  pid_q  <= reg_wdata;
            if (wr_inp)  inp_q  <= reg_wdata[7:0];
            if (wr_alm)  alm_q  <= reg_wdata[7:0];
            if (wr_mask) mask_q <= reg_wdata[ST_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // setup consistency check
    sce_cfg_check u_check (
        .ref_clk (ref_clk),
        .rst     (rst),
        .cfg     (cfg),
        .code_q  (cfg_code)
    );

    ////////////////////////////////////////////////////////////////////////////
    // remote request check, lowest code first
    wire          fc_ok   = req.func == FC_READ || req.func == FC_WRITE;
    wire          is_wr   = req.func == FC_WRITE;
    wire          addr_ok = req.addr < 16'(REG_COUNT);
    wire [IW-1:0] idx     = req.addr[IW-1:0];
    wire          present = PARAM_PRESENT[idx];
    wire          rd_only = PARAM_READ_ONLY[idx];
    wire          over    = req.data > VALUE_MAX;
    wire [7:0]    comm_code = !fc_ok            ? CE_FUNC  :
                              !addr_ok          ? CE_ADDR  :
                              !present          ? CE_PARAM :
                              (is_wr && rd_only) ? CE_RO    :
                              (is_wr && over)   ? CE_RANGE :
                              ERR_NONE;
    wire          comm_err = req.valid && comm_code != ERR_NONE;
    // a faulty write never reaches the store
    wire          par_we_d = req.valid && is_wr && comm_code == ERR_NONE;

    // answer and store write one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resp   <= '0;
            par_wr <= '0;
        end else begin
            resp.valid  <= req.valid;
            resp.code   <= req.valid ? comm_code : ERR_NONE;
            par_wr.we   <= par_we_d;
            par_wr.addr <= req.addr;
            par_wr.data <= req.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event pin synchroniser; the second and third stages feed the change detector
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_s1_q <= 1'b0;
            evt_s2_q <= 1'b0;
            evt_s3_q <= 1'b0;
        end else begin
            evt_s1_q <= event_pin;
            evt_s2_q <= evt_s1_q;
            evt_s3_q <= evt_s2_q;
        end
    end

    // tuning faults; a reported pid range fault counts as a failed run
    wire tune_fail = tune_active && (tune_pid_bad || tune_abort);
    wire tune_evt  = tune_active && (evt_s2_q != evt_s3_q);

    // latched event code: new event wins over a software clear
    wire [7:0] evt_code_d = tune_fail ? TE_FAIL  :
                            tune_evt  ? TE_EVENT :
                            comm_err  ? comm_code :
                            err_clr   ? ERR_NONE : evt_code_q;

    // setup faults outrank latched events, since they block control
    wire [7:0] err_code_d = (cfg_code != ERR_NONE) ? cfg_code : evt_code_d;

    ////////////////////////////////////////////////////////////////////////////
    // sticky status; set beats the read clear in the same cycle
    wire [ST_W-1:0] stat_set;
    wire [ST_W-1:0] stat_d;
    wire [ST_W-1:0] mask_d = wr_mask ? reg_wdata[ST_W-1:0] : mask_q;
    assign stat_set[ST_SETUP] = cfg_code != ERR_NONE && cfg_code != cfg_prev_q;
    assign stat_set[ST_COMM]  = comm_err;
    assign stat_set[ST_TUNE]  = tune_fail || tune_evt;

    genvar gi;
    generate
        for (gi = 0; gi < ST_W; gi++) begin : g_stat
            assign stat_d[gi] = stat_set[gi] || (stat_q[gi] && !rd_stat);
        end
    endgenerate

    // read data mux, unmapped offsets read zero
    wire [31:0] rd_mux =
        (reg_addr == OFF_SRC)  ? {28'h000_0000, src_q}           :
        (reg_addr == OFF_OUT)  ? {29'h0000_0000, out_q}          :
        (reg_addr == OFF_PID)  ? pid_q                           :
        (reg_addr == OFF_INP)  ? {24'h00_0000, inp_q}            :
        (reg_addr == OFF_ALM)  ? {24'h00_0000, alm_q}            :
        (reg_addr == OFF_STAT) ? {29'h0000_0000, stat_q}         :
        (reg_addr == OFF_MASK) ? {29'h0000_0000, mask_q}         :
        (reg_addr == OFF_ERR)  ? {24'h00_0000, err_code}         :
        32'h0000_0000;

    // alarm two drives output two only when its function exists
    wire alarm_d = cfg.output_two_function == O2_ALARM &&
                   cfg.alarm_two_function != ALM_NONE && alarm_two_raw;

    ////////////////////////////////////////////////////////////////////////////
    // report registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat_q        <= '0;
            evt_code_q    <= ERR_NONE;
            cfg_prev_q    <= ERR_NONE;
            err_code      <= ERR_NONE;
            irq           <= 1'b0;
            reg_rdata     <= 32'h0000_0000;
            alarm_two_out <= 1'b0;
        end else begin
            stat_q        <= stat_d;
            evt_code_q    <= evt_code_d;
            cfg_prev_q    <= cfg_code;
            err_code      <= err_code_d;
            irq           <= |(stat_d & mask_d);
            reg_rdata     <= reg_rd ? rd_mux : 32'h0000_0000;
            alarm_two_out <= alarm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks next to the logic
    a_bad_func: assert property (@(posedge ref_clk) disable iff (rst)
        req.valid && !fc_ok |=> resp.valid && resp.code == CE_FUNC)
        else $error("bad function code not answered with 10");
    a_addr_range: assert property (@(posedge ref_clk) disable iff (rst)
        req.valid && fc_ok && req.addr >= 16'(REG_COUNT) |=> resp.code == CE_ADDR)
        else $error("out of range address not answered with 11");
    a_no_param: assert property (@(posedge ref_clk) disable iff (rst)
        req.valid && fc_ok && addr_ok && !PARAM_PRESENT[idx] |=> resp.code == CE_PARAM)
        else $error("absent parameter not answered with 12");
    a_read_only: assert property (@(posedge ref_clk) disable iff (rst)
        req.valid && is_wr && addr_ok && present && PARAM_READ_ONLY[idx]
        |=> resp.code == CE_RO && !par_wr.we)
        else $error("read-only write not answered with 14");
    a_value_range: assert property (@(posedge ref_clk) disable iff (rst)
        req.valid && is_wr && addr_ok && present && !rd_only && req.data > VALUE_MAX
        |=> resp.code == CE_RANGE) else $error("over-range write not answered with 15");
    a_err_no_write: assert property (@(posedge ref_clk) disable iff (rst)
        resp.valid && resp.code != ERR_NONE |-> !par_wr.we)
        else $error("faulty request reached the store");
    a_tune_fail: assert property (@(posedge ref_clk) disable iff (rst)
        tune_active && tune_pid_bad |=> evt_code_q == TE_FAIL && stat_q[ST_TUNE])
        else $error("tuning failure not coded 20");
    a_event_chg: assert property (@(posedge ref_clk) disable iff (rst)
        tune_active && evt_s2_q != evt_s3_q && !tune_pid_bad && !tune_abort
        |=> evt_code_q == TE_EVENT) else $error("event change in tuning not coded 26");
    a_alarm_gate: assert property (@(posedge ref_clk) disable iff (rst)
        cfg.alarm_two_function == ALM_NONE |=> !alarm_two_out)
        else $error("alarm driven with function none");
    a_rd_clear: assert property (@(posedge ref_clk) disable iff (rst)
        rd_stat && stat_set == '0 |=> stat_q == '0 ##1 !irq || stat_q != '0)
        else $error("status read did not clear");
    // report path and bus checks
    a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
        irq == (|(stat_q & mask_q))) else $error("interrupt level out of step with status");
    a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (rst)
        stat_set != '0 |=> (stat_q & $past(stat_set)) == $past(stat_set))
        else $error("status event lost to a read clear");
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data outside read cycle");
    a_setup_first: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_code != ERR_NONE |=> err_code == $past(cfg_code))
        else $error("setup code not reported");
    a_comm_latch: assert property (@(posedge ref_clk) disable iff (rst)
        comm_err && !tune_fail && !tune_evt |=> evt_code_q == $past(comm_code))
        else $error("remote error code not latched");
    a_clear_loses: assert property (@(posedge ref_clk) disable iff (rst)
        err_clr && (tune_fail || tune_evt || comm_err) |=> evt_code_q != ERR_NONE)
        else $error("new event lost to a software clear");
    a_good_write: assert property (@(posedge ref_clk) disable iff (rst)
        par_we_d |=> par_wr.we && par_wr.addr == $past(req.addr))
        else $error("accepted write not passed to the store");
    a_alarm_pass: assert property (@(posedge ref_clk) disable iff (rst)
        cfg.output_two_function == O2_ALARM && cfg.alarm_two_function != ALM_NONE &&
        alarm_two_raw |=> alarm_two_out) else $error("enabled alarm two not driven");
endmodule

// ==== test_setup_check_error_reporter.sv ====
// testbench: setup checks, remote request checks and tuning faults of the reporter
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end
module test_setup_check_error_reporter;
    timeunit 1ns;
    timeprecision 1ps;
    import sce_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    // design signals
    logic        ref_clk, rst, reg_wr, reg_rd, irq, alarm_two_out;
    logic        tune_active, tune_pid_bad, tune_abort, event_pin, alarm_two_raw;
    logic [7:0]  reg_addr, err_code;
    logic [31:0] reg_wdata, reg_rdata, rdata;
    sce_req_t    req;
    sce_resp_t   resp;
    sce_par_t    par_wr;
    int          n_fail = 0;
    int          cmp_count = 0;
    // setup rows: src, out, pid, inp, alm, expected code; neighbours differ on purpose
    logic [71:0] setup_rows [13] = '{72'h00_00_14141414_00_00_00, 72'h04_00_14141414_00_00_01,
        72'h09_00_14141414_00_00_02, 72'h06_00_14141414_00_00_03, 72'h00_03_14141414_00_00_04,
        72'h00_02_14141400_00_00_04, 72'h02_00_14141414_01_00_05, 72'h00_04_14141414_00_00_06,
        72'h00_04_14141414_00_20_00, 72'h00_00_14141414_00_11_07, 72'h0B_00_14141414_00_00_03,
        72'h00_00_14141414_04_03_05, 72'h00_00_14141414_00_00_00};
    // remote rows: function, address, data, expected answer code
    logic [47:0] comm_rows [8] = '{48'h06_0010_0005_00, 48'h05_0010_0005_0A,
        48'h03_0040_0000_0B, 48'h03_0030_0000_0C, 48'h06_0002_0001_0E,
        48'h06_0010_2710_0F, 48'h03_0002_0000_00, 48'h06_0011_270F_00};
    ////////////////////////////////////////////////////////////////////////////
    always #2 ref_clk = ~ref_clk;
    sce_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .resp(resp),
        .par_wr(par_wr), .tune_active(tune_active), .tune_pid_bad(tune_pid_bad),
        .tune_abort(tune_abort), .event_pin(event_pin), .alarm_two_raw(alarm_two_raw),
        .alarm_two_out(alarm_two_out), .err_code(err_code), .irq(irq));
    sce_master m (.ref_clk(ref_clk), .req(req));
    ////////////////////////////////////////////////////////////////////////////
    // register port cycles, strobe one cycle each
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rdata = reg_rdata;
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // event pin codes arrive after a synchroniser, so poll with a bound
    task automatic wait_code(input logic [7:0] ex);
        int i;
        for (i = 0; i < 20 && err_code !== ex; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK("err_code", ex, err_code)
        if (err_code !== ex) close_out();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [71:0] r;
        logic [47:0] c;
        logic        ew;
        {ref_clk, rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b01, 42'h0};
        {tune_active, tune_pid_bad, tune_abort, event_pin, alarm_two_raw} = 5'b00001;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(OFF_PID);
        `CHK("pid_rst", PID_RST, rdata)
        @(posedge ref_clk);
        #1 `CHK("rdata_one_cycle", 32'h0, reg_rdata)
        rd(OFF_MASK);
        `CHK("mask_rst", 32'h0, rdata)
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20);
        `CHK("unmapped", 32'h0, rdata)
        // setup table: code fixed two cycles after the last write
        for (int k = 0; k < 13; k++) begin
            r = setup_rows[k];
            wr(OFF_SRC, {24'h0, r[71:64]});
            wr(OFF_OUT, {24'h0, r[63:56]});
            wr(OFF_PID, r[55:24]);
            wr(OFF_INP, {24'h0, r[23:16]});
            wr(OFF_ALM, {24'h0, r[15:8]});
            repeat (2) @(posedge ref_clk);
            #1;
            ew = (r[58:57] == O2_ALARM) && (r[15:12] != ALM_NONE);
            `CHK("setup_code", r[7:0], err_code)
            `CHK("alarm_two_out", ew, alarm_two_out)
        end
        // remote table: answer exactly one cycle after the request
        for (int k = 0; k < 8; k++) begin
            c = comm_rows[k];
            m.send(c[47:40], c[39:24], c[23:8]);
            #1;
            ew = (c[7:0] == 8'h00) && (c[47:40] == FC_WRITE);
            `CHK("resp_code", c[7:0], resp.code)
            `CHK("resp_valid", 1'b1, resp.valid)
            `CHK("par_we", ew, par_wr.we)
            if (ew) `CHK("par_data", c[23:8], par_wr.data)
            if (ew) `CHK("par_addr", c[39:24], par_wr.addr)
        end
        rd(OFF_STAT);
        `CHK("stat_comm", 1'b1, rdata[ST_COMM])
        `CHK("stat_setup", 1'b1, rdata[ST_SETUP])
        wr(OFF_ERR, 32'h0);
        wait_code(ERR_NONE);
        wr(OFF_MASK, 32'h4);
        // tuning run; setpoint left untouched throughout
        tune_active <= 1'b1;
        tune_abort <= 1'b1;
        @(posedge ref_clk);
        tune_abort <= 1'b0;
        wait_code(TE_FAIL);
        repeat (2) @(posedge ref_clk);
        #1 `CHK("irq_up", 1'b1, irq)
        rd(OFF_STAT);
        `CHK("stat_tune", 32'h4, rdata)
        repeat (2) @(posedge ref_clk);
        #1 `CHK("irq_clear", 1'b0, irq)
        wr(OFF_ERR, 32'h0);
        wait_code(ERR_NONE);
        @(posedge ref_clk);
        tune_pid_bad <= 1'b1;
        @(posedge ref_clk);
        tune_pid_bad <= 1'b0;
        wait_code(TE_FAIL);
        wr(OFF_MASK, 32'h0);
        wr(OFF_ERR, 32'h0);
        wait_code(ERR_NONE);
        @(posedge ref_clk);
        event_pin <= 1'b1;
        wait_code(TE_EVENT);
        `CHK("irq_masked", 1'b0, irq)
        // second reset in mid-run: tuning run ends, latched code and outputs cleared
        @(posedge ref_clk);
        tune_active <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1 `CHK("err_after_rst", ERR_NONE, err_code)
        @(posedge ref_clk);
        #1 `CHK("irq_after_rst", 1'b0, irq)
        `CHK("resp_after_rst", 1'b0, resp.valid)
        @(posedge ref_clk);
        #1 `CHK("err_edge_two", ERR_NONE, err_code)
        rd(OFF_PID);
        `CHK("pid_after_rst", PID_RST, rdata)
        close_out();
    end
    // overall watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        close_out();
    end
endmodule
